/* src/fpt_ctrl.v */
// Local design decisions: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
`include "fpt_map.vh"

module fpt_ctrl (
	input  wire                      SYS_CLK_I,
	input  wire                      RST_N_I,
	input  wire                      NV_FACTORY_N_I,
	input  wire                      PSEL_I,
	input  wire                      PENABLE_I,
	input  wire                      PWRITE_I,
	input  wire [11:0]               PADDR_I,
	input  wire [31:0]               PWDATA_I,
	output reg  [31:0]               PRDATA_O,
	output reg                       PREADY_O,
	output reg                       PSLVERR_O,
	input  wire                      FETCH_REQ_I,
	input  wire [`FPT_BADDR_W-1:0]   FETCH_ADDR_I,
	output reg  [31:0]               FETCH_DATA_O,
	output reg                       FETCH_VALID_O,
	input  wire                      DATA_REQ_I,
	input  wire [`FPT_BADDR_W-1:0]   DATA_ADDR_I,
	output reg  [31:0]               DATA_RDATA_O,
	output reg                       DATA_VALID_O,
	output reg                       DATA_DENIED_O,
	output reg                       IRQ_O
);

	localparam ST_IDLE = 2'b00;
	localparam ST_WALK = 2'b01;
	localparam ST_WAIT = 2'b10;

	reg  [`FPT_BADDR_W-1:0]  flash_address_reg;
	reg  [31:0]              flash_data_reg;
	reg  [7:0]               microsecond_reload;
	reg  [`FPT_UNITS-1:0]    program_enable_bits;
	reg  [`FPT_UNITS-1:0]    read_enable_bits;
	reg  [`FPT_UNITS-1:0]    committed_pe;
	reg  [`FPT_UNITS-1:0]    committed_re;
	reg  [`FPT_ST_W-1:0]     status;
	reg  [`FPT_ST_W-1:0]     flash_interrupt_mask;
	reg  [1:0]               state;
	reg                      op_erase;
	reg                      op_prog;
	reg                      op_merase;
	reg  [`FPT_WADDR_W-1:0]  ptr;
	reg  [`FPT_WADDR_W-1:0]  ptr_end;
	reg  [7:0]               pre_cnt;
	reg  [7:0]               us_cnt;
	reg  [7:0]               us_target;
	reg  [31:0]              next_rdata;
	reg                      next_err;
	reg                      fac_meta;
	reg                      fac_sync;
	wire                     apb_access;
	wire                     apb_done;
	wire                     wr_fire;
	wire                     ctl_write;
	wire                     key_ok;
	wire                     start_prog;
	wire                     start_erase;
	wire                     start_merase;
	wire                     start_any;
	wire                     start_commit;
	wire [3:0]               op_unit;
	wire                     op_allowed;
	wire                     prog_viol_ev;
	wire                     read_viol_ev;
	wire                     done_ev;
	wire                     us_tick;
	wire                     access_violation_mask;
	wire [`FPT_ST_W-1:0]     ev;
	wire [`FPT_ST_W-1:0]     clr;
	wire [`FPT_ST_W-1:0]     next_status;
	wire [31:0]              fetch_word;
	wire [31:0]              data_word;
	wire                     data_unit_re;
	wire                     next_irq;

	// APB handshake: answer comes one cycle into the access phase
	assign apb_access = PSEL_I & PENABLE_I;
	assign apb_done   = apb_access & PREADY_O;
	assign wr_fire    = apb_done & PWRITE_I;

	always @(posedge SYS_CLK_I) begin
		if (!RST_N_I) begin
			PREADY_O  <= 1'b0;
			PRDATA_O  <= 32'h0000_0000;
			PSLVERR_O <= 1'b0;
		end else begin
			PREADY_O  <= apb_access & ~PREADY_O;
			PRDATA_O  <= (apb_access & ~PREADY_O & ~PWRITE_I) ? next_rdata : 32'h0000_0000;
			PSLVERR_O <= apb_access & ~PREADY_O & next_err;
		end
	end

	// Read mux and unmapped decode
	always @* begin
		next_rdata = 32'h0000_0000;
		next_err   = 1'b0;
		case (PADDR_I)
			`FPT_OFF_ADDRESS: next_rdata[`FPT_BADDR_W-1:0] = flash_address_reg;
			`FPT_OFF_DATA:    next_rdata = flash_data_reg;
			`FPT_OFF_CONTROL: begin
				next_rdata[`FPT_CTL_WRITE]  = (state != ST_IDLE) & op_prog;
				next_rdata[`FPT_CTL_ERASE]  = (state != ST_IDLE) & op_erase;
				next_rdata[`FPT_CTL_MERASE] = (state != ST_IDLE) & op_merase;
			end
			`FPT_OFF_STATUS:  next_rdata[`FPT_ST_W-1:0] = status;
			`FPT_OFF_ENABLE:  next_rdata[`FPT_ST_W-1:0] = flash_interrupt_mask;
			`FPT_OFF_CLEAR:   next_rdata = 32'h0000_0000;
			`FPT_OFF_READ_EN: next_rdata[`FPT_UNITS-1:0] = read_enable_bits;
			`FPT_OFF_PROG_EN: next_rdata[`FPT_UNITS-1:0] = program_enable_bits;
			`FPT_OFF_USEC:    next_rdata[7:0] = microsecond_reload;
			default:          next_err = 1'b1;
		endcase
	end

	// Plain configuration registers
	always @(posedge SYS_CLK_I) begin
		if (!RST_N_I) begin
			flash_address_reg    <= {`FPT_BADDR_W{1'b0}};
			flash_data_reg       <= 32'h0000_0000;
			flash_interrupt_mask <= {`FPT_ST_W{1'b0}};
			microsecond_reload   <= `FPT_USEC_RESET;
		end else if (wr_fire) begin
			case (PADDR_I)
				`FPT_OFF_ADDRESS: flash_address_reg <= PWDATA_I[`FPT_BADDR_W-1:0];
				`FPT_OFF_DATA:    flash_data_reg <= PWDATA_I;
				`FPT_OFF_ENABLE:  flash_interrupt_mask <= PWDATA_I[`FPT_ST_W-1:0];
				`FPT_OFF_USEC:    microsecond_reload <= PWDATA_I[7:0];
				default:          flash_address_reg <= flash_address_reg;
			endcase
		end
	end

	// Control register decode
	assign ctl_write    = wr_fire & (PADDR_I == `FPT_OFF_CONTROL);
	assign key_ok       = PWDATA_I[`FPT_KEY_HI:`FPT_KEY_LO] == `FPT_KEY_VALUE;
	assign start_prog   = ctl_write & key_ok & PWDATA_I[`FPT_CTL_WRITE] & (state == ST_IDLE);
	assign start_erase  = ctl_write & key_ok & PWDATA_I[`FPT_CTL_ERASE] & (state == ST_IDLE)
		& ~PWDATA_I[`FPT_CTL_WRITE];
	assign start_merase = ctl_write & key_ok & PWDATA_I[`FPT_CTL_MERASE] & (state == ST_IDLE)
		& ~PWDATA_I[`FPT_CTL_WRITE] & ~PWDATA_I[`FPT_CTL_ERASE];
	assign start_any    = start_prog | start_erase | start_merase;
	assign start_commit = ctl_write & key_ok & PWDATA_I[`FPT_CTL_COMMIT];

	// Unit of the target address
	assign op_unit    = flash_address_reg[`FPT_UNIT_HI:`FPT_UNIT_LO];
	assign op_allowed = start_merase ? (&program_enable_bits)
		: program_enable_bits[op_unit];

	assign prog_viol_ev = start_any & ~op_allowed;

	// Factory-state input passes two flip-flops before use
	always @(posedge SYS_CLK_I) begin
		fac_meta <= NV_FACTORY_N_I;
		fac_sync <= fac_meta;
	end

	// Protection bits, working copy and committed copy
	always @(posedge SYS_CLK_I) begin
		if (!fac_sync) begin
			committed_pe <= `FPT_PROT_FACTORY;
			committed_re <= `FPT_PROT_FACTORY;
		end else if (start_commit) begin
			if (flash_address_reg[`FPT_ADDR_SEL_PROG]) begin
				committed_pe <= committed_pe & program_enable_bits;
			end else begin
				committed_re <= committed_re & read_enable_bits;
			end
		end
	end

	always @(posedge SYS_CLK_I) begin
		if (!RST_N_I) begin
			program_enable_bits <= committed_pe;
			read_enable_bits    <= committed_re;
		end else if (wr_fire) begin
			if (PADDR_I == `FPT_OFF_PROG_EN) begin
				program_enable_bits <= PWDATA_I[`FPT_UNITS-1:0] & committed_pe;
			end
			if (PADDR_I == `FPT_OFF_READ_EN) begin
				read_enable_bits <= PWDATA_I[`FPT_UNITS-1:0] & committed_re;
			end
		end
	end

	// Microsecond tick from the reload count
	assign us_tick = (pre_cnt == microsecond_reload);

	// Program and erase sequencer
	always @(posedge SYS_CLK_I) begin
		if (!RST_N_I) begin
			state     <= ST_IDLE;
			op_prog   <= 1'b0;
			op_erase  <= 1'b0;
			op_merase <= 1'b0;
			ptr       <= {`FPT_WADDR_W{1'b0}};
			ptr_end   <= {`FPT_WADDR_W{1'b0}};
			pre_cnt   <= 8'h00;
			us_cnt    <= 8'h00;
			us_target <= 8'h00;
		end else begin
			case (state)
				ST_IDLE: begin
					if (start_any & op_allowed) begin
						state     <= ST_WALK;
						op_prog   <= start_prog;
						op_erase  <= start_erase;
						op_merase <= start_merase;
						us_target <= start_prog ? `FPT_PROG_US : `FPT_ERASE_US;
						if (start_prog) begin
							ptr     <= flash_address_reg[`FPT_BADDR_W-1:`FPT_WORD_LO];
							ptr_end <= flash_address_reg[`FPT_BADDR_W-1:`FPT_WORD_LO];
						end else if (start_erase) begin
							ptr <= {flash_address_reg[`FPT_BADDR_W-1:`FPT_BLOCK_SEL_LO],
								`FPT_BLOCK_FIRST};
							ptr_end <= {flash_address_reg[`FPT_BADDR_W-1:`FPT_BLOCK_SEL_LO],
								`FPT_BLOCK_WORDS_M1};
						end else begin
							ptr     <= {`FPT_WADDR_W{1'b0}};
							ptr_end <= `FPT_LAST_WORD;
						end
					end
				end
				ST_WALK: begin
					if (ptr == ptr_end) begin
						state   <= ST_WAIT;
						pre_cnt <= 8'h00;
						us_cnt  <= 8'h00;
					end else begin
						ptr <= ptr + {{(`FPT_WADDR_W-1){1'b0}}, 1'b1};
					end
				end
				ST_WAIT: begin
					if (us_tick) begin
						pre_cnt <= 8'h00;
						us_cnt  <= us_cnt + 8'h01;
					end else begin
						pre_cnt <= pre_cnt + 8'h01;
					end
					if (us_tick & (us_cnt + 8'h01 >= us_target)) begin
						state     <= ST_IDLE;
						op_prog   <= 1'b0;
						op_erase  <= 1'b0;
						op_merase <= 1'b0;
					end
				end
				default: begin
					state <= ST_IDLE;
				end
			endcase
		end
	end

	assign done_ev = (state == ST_WAIT) & us_tick & (us_cnt + 8'h01 >= us_target);

	fpt_array u_array (
		.clk_i        (SYS_CLK_I),
		.wr_en_i      (state == ST_WALK),
		.wr_erase_i   (~op_prog),
		.wr_addr_i    (ptr),
		.wr_data_i    (flash_data_reg),
		.fetch_addr_i (FETCH_ADDR_I[`FPT_BADDR_W-1:`FPT_WORD_LO]),
		.fetch_word_o (fetch_word),
		.data_addr_i  (DATA_ADDR_I[`FPT_BADDR_W-1:`FPT_WORD_LO]),
		.data_word_o  (data_word),
		.prog_word_o  ()
	);

	// Read paths: fetch always served, data gated by read enable
	assign data_unit_re = read_enable_bits[DATA_ADDR_I[`FPT_UNIT_HI:`FPT_UNIT_LO]];
	assign read_viol_ev = DATA_REQ_I & ~data_unit_re;

	always @(posedge SYS_CLK_I) begin
		if (!RST_N_I) begin
			FETCH_VALID_O <= 1'b0;
			FETCH_DATA_O  <= 32'h0000_0000;
			DATA_VALID_O  <= 1'b0;
			DATA_DENIED_O <= 1'b0;
			DATA_RDATA_O  <= 32'h0000_0000;
		end else begin
			FETCH_VALID_O <= FETCH_REQ_I;
			FETCH_DATA_O  <= FETCH_REQ_I ? fetch_word : 32'h0000_0000;
			DATA_VALID_O  <= DATA_REQ_I;
			DATA_DENIED_O <= read_viol_ev;
			if (DATA_REQ_I & data_unit_re) begin
				DATA_RDATA_O <= data_word;
			end else begin
				DATA_RDATA_O <= 32'h0000_0000;
			end
		end
	end

	// Sticky status: set wins over clear
	assign access_violation_mask = flash_interrupt_mask[`FPT_ST_PROG_VIOL];
	assign ev[`FPT_ST_PROG_VIOL] = prog_viol_ev;
	assign ev[`FPT_ST_READ_VIOL] = read_viol_ev;
	assign ev[`FPT_ST_DONE]      = done_ev;

	genvar gi;
	generate
		for (gi = 0; gi < `FPT_ST_W; gi = gi + 1) begin : g_status
			assign clr[gi]         = wr_fire & (PADDR_I == `FPT_OFF_CLEAR) & PWDATA_I[gi];
			assign next_status[gi] = ev[gi] | (status[gi] & ~clr[gi]);
		end
	endgenerate

	assign next_irq = (next_status[`FPT_ST_PROG_VIOL] & access_violation_mask)
		| |(next_status[`FPT_ST_W-1:1] & flash_interrupt_mask[`FPT_ST_W-1:1]);

	always @(posedge SYS_CLK_I) begin
		if (!RST_N_I) begin
			status <= {`FPT_ST_W{1'b0}};
			IRQ_O  <= 1'b0;
		end else begin
			status <= next_status;
			IRQ_O  <= next_irq;
		end
	end

endmodule // fpt_ctrl

`default_nettype wire

/* pkg/fpt_map.vh */
`ifndef FPT_MAP_VH
`define FPT_MAP_VH

// Register byte offsets
`define FPT_OFF_ADDRESS      12'h000
`define FPT_OFF_DATA         12'h004
`define FPT_OFF_CONTROL      12'h008
`define FPT_OFF_STATUS       12'h00c
`define FPT_OFF_ENABLE       12'h010
`define FPT_OFF_CLEAR        12'h014
`define FPT_OFF_READ_EN      12'h130
`define FPT_OFF_PROG_EN      12'h134
`define FPT_OFF_USEC         12'h140

// Control register fields
`define FPT_KEY_HI           31
`define FPT_KEY_LO           16
`define FPT_KEY_VALUE        16'ha442
`define FPT_CTL_WRITE        0
`define FPT_CTL_ERASE        1
`define FPT_CTL_MERASE       2
`define FPT_CTL_COMMIT       3

// Status bit positions
`define FPT_ST_PROG_VIOL     0
`define FPT_ST_READ_VIOL     1
`define FPT_ST_DONE          2
`define FPT_ST_W             3

// Array geometry
`define FPT_BADDR_W          15
`define FPT_WADDR_W          13
`define FPT_UNIT_HI          14
`define FPT_UNIT_LO          11
`define FPT_UNITS            16
`define FPT_BLOCK_HI         12
`define FPT_BLOCK_LO         8
`define FPT_WORD_LO          2
`define FPT_BLOCK_SEL_LO     10
`define FPT_BLOCK_FIRST      8'h00
`define FPT_BLOCK_WORDS_M1   8'hff
`define FPT_LAST_WORD        13'h1fff
`define FPT_WORD_ONES        32'hffffffff

// Reset and factory values
`define FPT_USEC_RESET       8'h31
`define FPT_PROT_FACTORY     16'hffff
`define FPT_ADDR_SEL_PROG    0

// Operation times in microseconds
`define FPT_PROG_US          8'h14
`define FPT_ERASE_US         8'h64

`endif

/* src/fpt_array.v */
`timescale 1ns/1ps
`default_nettype none
`include "fpt_map.vh"

module fpt_array (
	input  wire                      clk_i,
	input  wire                      wr_en_i,
	input  wire                      wr_erase_i,
	input  wire [`FPT_WADDR_W-1:0]   wr_addr_i,
	input  wire [31:0]               wr_data_i,
	input  wire [`FPT_WADDR_W-1:0]   fetch_addr_i,
	output wire [31:0]               fetch_word_o,
	input  wire [`FPT_WADDR_W-1:0]   data_addr_i,
	output wire [31:0]               data_word_o,
	output wire [31:0]               prog_word_o
);

	reg [31:0] mem [0:(1<<`FPT_WADDR_W)-1];

	assign fetch_word_o = mem[fetch_addr_i];
	assign data_word_o  = mem[data_addr_i];
	assign prog_word_o  = mem[wr_addr_i];

	// Erase writes ones; programming can only clear bits
	always @(posedge clk_i) begin
		if (wr_en_i) begin
			if (wr_erase_i) begin
				mem[wr_addr_i] <= `FPT_WORD_ONES;
			end else begin
				mem[wr_addr_i] <= mem[wr_addr_i] & wr_data_i;
			end
		end
	end

endmodule // fpt_array

`default_nettype wire

/* bench/fpt_ctrl_properties.sv */
`timescale 1ns/1ps
`default_nettype none
module fpt_ctrl_chk (
	input wire logic        SYS_CLK_I,
	input wire logic        RST_N_I,
	input wire logic        PSEL_I,
	input wire logic        PENABLE_I,
	input wire logic        PWRITE_I,
	input wire logic [11:0] PADDR_I,
	input wire logic [31:0] PRDATA_O,
	input wire logic        PREADY_O,
	input wire logic        FETCH_REQ_I,
	input wire logic        FETCH_VALID_O,
	input wire logic        DATA_REQ_I,
	input wire logic [31:0] DATA_RDATA_O,
	input wire logic        DATA_VALID_O,
	input wire logic        DATA_DENIED_O
);
	default clocking cb @(posedge SYS_CLK_I);
	endclocking
	default disable iff (!RST_N_I);
	property p_ready_pulse;
		PREADY_O |=> !PREADY_O;
	endproperty
	a_ready_pulse: assert property (p_ready_pulse) else $error("ready held too long");
	property p_ready_cause;
		PREADY_O |-> PSEL_I && PENABLE_I && $past(PSEL_I && PENABLE_I);
	endproperty
	a_ready_cause: assert property (p_ready_cause) else $error("ready without access");
	property p_ready_bound;
		PSEL_I && PENABLE_I |-> ##[0:1] PREADY_O;
	endproperty
	a_ready_bound: assert property (p_ready_bound) else $error("ready late");
	property p_rdata_idle;
		!PREADY_O |-> PRDATA_O == 32'h0;
	endproperty
	a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside answer");
	property p_clear_zero;
		PREADY_O && !PWRITE_I && PADDR_I == 12'h014 |-> PRDATA_O == 32'h0;
	endproperty
	a_clear_zero: assert property (p_clear_zero) else $error("clear register not zero");
	property p_fetch_valid;
		FETCH_VALID_O == $past(FETCH_REQ_I);
	endproperty
	a_fetch_valid: assert property (p_fetch_valid) else $error("fetch answer wrong");
	property p_data_valid;
		DATA_VALID_O == $past(DATA_REQ_I);
	endproperty
	a_data_valid: assert property (p_data_valid) else $error("data answer wrong");
	property p_denied_zero;
		DATA_DENIED_O |-> DATA_VALID_O && DATA_RDATA_O == 32'h0;
	endproperty
	a_denied_zero: assert property (p_denied_zero) else $error("refused read not zero");
endmodule // fpt_ctrl_chk
`default_nettype wire

/* bench/fpt_core_model.sv */
`timescale 1ns/1ps
`default_nettype none
module fpt_core_model (
	input  wire logic        clk_i,
	output var  logic        fetch_req_o,
	output var  logic [14:0] fetch_addr_o,
	input  wire logic        fetch_valid_i,
	input  wire logic [31:0] fetch_data_i,
	output var  logic        data_req_o,
	output var  logic [14:0] data_addr_o,
	input  wire logic        data_valid_i,
	input  wire logic [31:0] data_rdata_i,
	input  wire logic        data_denied_i
);
	initial begin
		fetch_req_o = 1'b0;
		fetch_addr_o = 15'h0;
		data_req_o = 1'b0;
		data_addr_o = 15'h0;
	end
	// One word request, held for one edge; address then shows its inverse
	task automatic access(input logic f, input logic [14:0] a, output logic [31:0] w,
		output logic den);
		if (f) begin
			fetch_req_o <= 1'b1;
			fetch_addr_o <= a;
		end else begin
			data_req_o <= 1'b1;
			data_addr_o <= a;
		end
		@(posedge clk_i);
		fetch_req_o <= 1'b0;
		data_req_o <= 1'b0;
		if (f)
			fetch_addr_o <= ~a;
		else
			data_addr_o <= ~a;
		@(posedge clk_i);
		w = f ? (fetch_valid_i ? fetch_data_i : 32'hx) : (data_valid_i ? data_rdata_i : 32'hx);
		den = f ? 1'b0 : data_denied_i;
	endtask
endmodule // fpt_core_model
`default_nettype wire

/* bench/tb_flash_protect_timing_ctrl.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_flash_protect_timing_ctrl;
	localparam logic [31:0] KEY = 32'ha442_0000;
	logic        clk;
	logic        rst_n;
	logic        fac_n;
	logic        psel;
	logic        pen;
	logic        pwr;
	logic [11:0] paddr;
	logic [31:0] pwdata;
	wire  [31:0] prdata;
	wire         pready;
	wire         pslverr;
	wire         f_req;
	wire  [14:0] f_addr;
	wire  [31:0] f_data;
	wire         f_vld;
	wire         d_req;
	wire  [14:0] d_addr;
	wire  [31:0] d_data;
	wire         d_vld;
	wire         d_den;
	wire         irq;
	logic        last_err;
	int          bad_count;
	int          num_checks;
	int          cycles;
	fpt_ctrl i_fpt_ctrl (.SYS_CLK_I(clk), .RST_N_I(rst_n), .NV_FACTORY_N_I(fac_n),
		.PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata),
		.PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr), .FETCH_REQ_I(f_req),
		.FETCH_ADDR_I(f_addr), .FETCH_DATA_O(f_data), .FETCH_VALID_O(f_vld),
		.DATA_REQ_I(d_req), .DATA_ADDR_I(d_addr), .DATA_RDATA_O(d_data),
		.DATA_VALID_O(d_vld), .DATA_DENIED_O(d_den), .IRQ_O(irq));
	fpt_core_model u_core (.clk_i(clk), .fetch_req_o(f_req), .fetch_addr_o(f_addr),
		.fetch_valid_i(f_vld), .fetch_data_i(f_data), .data_req_o(d_req),
		.data_addr_o(d_addr), .data_valid_i(d_vld), .data_rdata_i(d_data),
		.data_denied_i(d_den));
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	always @(posedge clk) begin
		cycles++;
		if (cycles == 60000) begin
			bad_count++;
			give_verdict();
		end
	end
	task automatic give_verdict();
		$display("Checks %0d, mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			bad_count++;
			$display("FAIL %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] r);
		psel <= 1'b1;
		pwr <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		pen <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1)
			@(posedge clk);
		r = prdata;
		last_err = pslverr;
		psel <= 1'b0;
		pen <= 1'b0;
		@(posedge clk);
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] r;
		apb(1'b1, a, d, r);
	endtask
	task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
		logic [31:0] r;
		apb(1'b0, a, 32'h0, r);
		chk($sformatf("register %h", a), e, r);
	endtask
	task automatic op(input logic [31:0] c);
		logic [31:0] r;
		wr(12'h008, KEY | c);
		r = 32'h7;
		while (r[2:0] !== 3'h0)
			apb(1'b0, 12'h008, 32'h0, r);
	endtask
	task automatic mem(input string n, input logic f, input logic [14:0] a,
		input logic [31:0] e, input logic den);
		logic [31:0] w;
		logic        x;
		u_core.access(f, a, w, x);
		chk(n, e, w);
		chk({n, " refusal"}, {31'h0, den}, {31'h0, x});
	endtask
	task automatic t_reset_vals();
		logic [31:0] r;
		rdchk(12'h130, 32'h0000_ffff);
		rdchk(12'h134, 32'h0000_ffff);
		rdchk(12'h140, 32'h0000_0031);
		rdchk(12'h014, 32'h0);
		apb(1'b0, 12'h020, 32'h0, r);
		chk("unmapped error", 32'h1, {31'h0, last_err});
		wr(12'h140, 32'h0000_0031);
	endtask
	task automatic t_erase_prog();
		op(32'h4);
		mem("mass erased", 1'b0, 15'h7ffc, 32'hffff_ffff, 1'b0);
		wr(12'h000, 32'h0000_0800);
		wr(12'h004, 32'ha5a5_f0f0);
		op(32'h1);
		op(32'h2);
		mem("block erased", 1'b0, 15'h0800, 32'hffff_ffff, 1'b0);
		op(32'h1);
		wr(12'h004, 32'h0ff0_ffff);
		op(32'h1);
		mem("programmed", 1'b0, 15'h0800, 32'h05a0_f0f0, 1'b0);
		mem("fetched", 1'b1, 15'h0800, 32'h05a0_f0f0, 1'b0);
	endtask
	task automatic t_prog_prot();
		wr(12'h010, 32'h0000_0003);
		wr(12'h134, 32'h0000_fffd);
		wr(12'h004, 32'h0);
		op(32'h1);
		op(32'h2);
		rdchk(12'h00c, 32'h0000_0005);
		chk("irq on violation", 32'h1, {31'h0, irq});
		mem("guarded word", 1'b0, 15'h0800, 32'h05a0_f0f0, 1'b0);
		wr(12'h014, 32'h0000_0007);
		chk("irq cleared", 32'h0, {31'h0, irq});
		wr(12'h010, 32'h0000_0002);
		op(32'h1);
		chk("irq masked", 32'h0, {31'h0, irq});
		wr(12'h014, 32'h0000_0007);
		wr(12'h134, 32'h0000_ffff);
		rdchk(12'h134, 32'h0000_ffff);
	endtask
	task automatic t_read_prot();
		wr(12'h130, 32'h0000_fffd);
		mem("read guarded", 1'b0, 15'h0800, 32'h0, 1'b1);
		mem("fetch guarded", 1'b1, 15'h0800, 32'h05a0_f0f0, 1'b0);
		chk("irq on read", 32'h1, {31'h0, irq});
		mem("read neighbour", 1'b0, 15'h07fc, 32'hffff_ffff, 1'b0);
		wr(12'h004, 32'h0000_f0f0);
		op(32'h1);
		mem("fetch rewritten", 1'b1, 15'h0800, 32'h0000_f0f0, 1'b0);
		wr(12'h014, 32'h0000_0007);
	endtask
	task automatic t_commit();
		wr(12'h000, 32'h0);
		op(32'h8);
		wr(12'h130, 32'h0000_ffff);
		rdchk(12'h130, 32'h0000_fffd);
		wr(12'h134, 32'h0000_fffe);
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		rdchk(12'h134, 32'h0000_ffff);
		rdchk(12'h130, 32'h0000_fffd);
		wr(12'h000, 32'h0000_0001);
		wr(12'h134, 32'h0000_fffe);
		op(32'h8);
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		rdchk(12'h134, 32'h0000_fffe);
		op(32'h1);
		rdchk(12'h00c, 32'h0000_0001);
		mem("locked word", 1'b0, 15'h0000, 32'hffff_ffff, 1'b0);
	endtask
	initial begin
		rst_n = 1'b0;
		fac_n = 1'b0;
		psel = 1'b0;
		pen = 1'b0;
		pwr = 1'b0;
		paddr = 12'h0;
		pwdata = 32'h0;
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		fac_n <= 1'b1;
		@(posedge clk);
		t_reset_vals();
		t_erase_prog();
		t_prog_prot();
		t_read_prot();
		t_commit();
		give_verdict();
	end
endmodule // tb_flash_protect_timing_ctrl
bind fpt_ctrl fpt_ctrl_chk i_chk (.SYS_CLK_I, .RST_N_I, .PSEL_I, .PENABLE_I, .PWRITE_I,
	.PADDR_I, .PRDATA_O, .PREADY_O, .FETCH_REQ_I, .FETCH_VALID_O, .DATA_REQ_I,
	.DATA_RDATA_O, .DATA_VALID_O, .DATA_DENIED_O);
`default_nettype wire
